// ==== design/sts_defines.svh ====
`ifndef STS_DEFINES_SVH
`define STS_DEFINES_SVH

`define STS_LIM_W 14
`define STS_LIM_MAX 14'h3fff
`define STS_PTR_W 32
`define STS_BYTE_W 8
`define STS_DRAIN_CYC 2'h3

`endif

// ==== design/sts_pkg.sv ====
`include "sts_defines.svh"

package sts_pkg;

	typedef enum logic [1:0] {
		STS_SEM_FREE = 2'b00,
		STS_SEM_CPU = 2'b01,
		STS_SEM_ENGINE = 2'b10
	} sts_sem_t;

	typedef enum logic [1:0] {
		STS_PH_IDLE = 2'b00,
		STS_PH_GRANTED = 2'b01,
		STS_PH_IGNORED = 2'b10,
		STS_PH_DRAIN = 2'b11
	} sts_phase_t;

	typedef struct packed {
		logic req;
		logic we;
		logic [`STS_PTR_W-1:0] addr;
		logic [`STS_BYTE_W-1:0] wdata;
	} sts_mem_req_t;

	typedef struct packed {
		logic ack;
		logic [`STS_BYTE_W-1:0] rdata;
	} sts_mem_rsp_t;

	typedef struct packed {
		logic en_d;
		sts_sem_t sem;
		sts_phase_t ph;
		logic csn_s1;
		logic csn_s2;
		logic csn_s3;
		logic tog_s1;
		logic tog_s2;
		logic tog_s3;
		logic take_pend;
		logic [1:0][`STS_BYTE_W-1:0] slot;
		logic [1:0] fetch_pend;
		logic [1:0][`STS_LIM_W-1:0] fetch_idx;
		logic [`STS_LIM_W-1:0] next_idx;
		logic par;
		logic [`STS_LIM_W-1:0] rx_cnt;
		logic [`STS_LIM_W-1:0] tx_cnt;
		logic wr_pend;
		logic [`STS_BYTE_W-1:0] wr_data;
		logic [`STS_LIM_W-1:0] wr_idx;
		logic busy_slot;
		logic busy_full;
		logic [1:0] drain_cnt;
		sts_mem_req_t mem;
		logic taken_ev;
		logic done_ev;
		logic full_ev;
		logic ovf;
		logic oread;
		logic [`STS_LIM_W-1:0] rx_tally;
		logic [`STS_LIM_W-1:0] tx_tally;
		logic miso_oe_b;
	} sts_core_t;

	typedef struct packed {
		logic [2:0] cnt;
		logic pb;
		logic started;
		logic [6:0] sh;
	} sts_lsamp_t;

	typedef struct packed {
		logic [`STS_BYTE_W-1:0] hold;
		logic tog;
	} sts_lbyte_t;

endpackage

// ==== design/sts_target.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "sts_defines.svh"

module sts_target
	import sts_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic enable,
	input wire logic cpol,
	input wire logic cpha,
	input wire logic shortcut_done_take,
	input wire logic take_task,
	input wire logic give_task,
	input wire logic status_clear,
	input wire logic [`STS_PTR_W-1:0] tx_buf_pointer,
	input wire logic [`STS_PTR_W-1:0] rx_buf_pointer,
	input wire logic [`STS_LIM_W-1:0] tx_buf_limit,
	input wire logic [`STS_LIM_W-1:0] rx_buf_limit,
	input wire logic [`STS_BYTE_W-1:0] ignored_fill_char,
	input wire logic [`STS_BYTE_W-1:0] tx_excess_flag_fill_char,
	output logic sem_taken_event,
	output logic xfer_done_event,
	output logic rx_buffer_full_event,
	output logic rx_overflow_flag,
	output logic tx_excess_flag,
	output logic [`STS_LIM_W-1:0] rx_byte_tally,
	output logic [`STS_LIM_W-1:0] tx_byte_tally,
	output sts_sem_t sem_owner,
	output sts_mem_req_t mem_req,
	input wire sts_mem_rsp_t mem_rsp,
	input wire logic sck,
	input wire logic csn_b,
	input wire logic mosi,
	output logic miso,
	output logic miso_oe_b
);

	sts_core_t q;
	sts_core_t n;
	sts_lsamp_t ls;
	sts_lbyte_t lb;
	logic miso_ff;
	logic link_clk;
	logic csn_fall;
	logic csn_rise;
	logic byte_ev;
	logic en_rise;
	logic fsel;

	// Mode inputs must be static while selected; the sample edge is
	// always the rising edge of this clock, the shift edge its falling.
	assign link_clk = sck ^ (cpol ^ cpha);

	// Link side: bit sampling, cleared while deselected
	always_ff @(posedge link_clk or posedge csn_b) begin
		if (csn_b) begin
			ls <= '0;
		end else begin
			ls.started <= 1'b1;
			ls.sh <= {ls.sh[5:0], mosi};
			ls.cnt <= ls.cnt + 3'h1;
			if (ls.cnt == 3'h7) begin
				ls.pb <= ~ls.pb;
			end
		end
	end

	// Byte toggle survives deselect so the core never sees a false event
	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			lb <= '0;
		end else if (ls.cnt == 3'h7) begin
			lb.hold <= {ls.sh, mosi};
			lb.tog <= ~lb.tog;
		end
	end

	// Slots are held stable by the core for a whole byte time
	always_ff @(negedge link_clk or posedge csn_b) begin
		if (csn_b) begin
			miso_ff <= 1'b0;
		end else begin
			miso_ff <= q.slot[ls.pb][~ls.cnt];
		end
	end

	// First bit in phase-0 modes has no shift edge before it
	assign miso = ls.started ? miso_ff : q.slot[0][7];
	assign miso_oe_b = q.miso_oe_b;

	assign csn_fall = q.csn_s3 && !q.csn_s2;
	assign csn_rise = !q.csn_s3 && q.csn_s2;
	assign byte_ev = q.tog_s3 != q.tog_s2;
	assign en_rise = enable && !q.en_d;
	assign fsel = !q.fetch_pend[0];

	always_comb begin
		n = q;
		n.taken_ev = 1'b0;
		n.done_ev = 1'b0;
		n.full_ev = 1'b0;
		n.en_d = enable;
		n.csn_s1 = csn_b;
		n.csn_s2 = q.csn_s1;
		n.csn_s3 = q.csn_s2;
		n.tog_s1 = lb.tog;
		n.tog_s2 = q.tog_s1;
		n.tog_s3 = q.tog_s2;
		n.miso_oe_b = q.csn_s2 || !enable;
		if (status_clear) begin
			n.ovf = 1'b0;
			n.oread = 1'b0;
		end
		if (!enable) begin
			n.sem = STS_SEM_FREE;
			n.ph = STS_PH_IDLE;
			n.take_pend = 1'b0;
			n.fetch_pend = 2'b00;
			n.wr_pend = 1'b0;
			n.mem.req = 1'b0;
		end else begin
			if (en_rise) begin
				n.sem = STS_SEM_CPU;
			end
			if (give_task && q.sem == STS_SEM_CPU) begin
				n.sem = STS_SEM_FREE;
			end
			// Give from any other owner falls through untouched
			if (take_task && !en_rise) begin
				case (q.sem)
					STS_SEM_CPU: begin
						n.taken_ev = 1'b1;
					end
					STS_SEM_FREE: begin
						n.sem = STS_SEM_CPU;
						n.taken_ev = 1'b1;
					end
					STS_SEM_ENGINE: begin
						n.take_pend = 1'b1;
					end
					default: begin
						n.sem = STS_SEM_FREE;
					end
				endcase
			end
			case (q.ph)
				STS_PH_IDLE: begin
					if (csn_fall) begin
						// Processor wins a same-cycle take
						if (q.sem == STS_SEM_FREE && !take_task && !en_rise) begin
							n.sem = STS_SEM_ENGINE;
							n.ph = STS_PH_GRANTED;
							// Counters restart, pointers reused
							n.rx_cnt = '0;
							n.tx_cnt = '0;
							n.par = 1'b0;
							n.next_idx = 14'h2;
							n.fetch_pend = 2'b00;
							for (int s = 0; s < 2; s++) begin
								if (14'(s) < tx_buf_limit) begin
									n.fetch_pend[s] = 1'b1;
									n.fetch_idx[s] = 14'(s);
								end else begin
									n.slot[s] = tx_excess_flag_fill_char;
								end
							end
						end else begin
							n.ph = STS_PH_IGNORED;
							n.slot[0] = ignored_fill_char;
							n.slot[1] = ignored_fill_char;
						end
					end
				end
				STS_PH_GRANTED: begin
					if (byte_ev) begin
						if (q.rx_cnt < rx_buf_limit) begin
							n.wr_pend = 1'b1;
							n.wr_data = lb.hold;
							n.wr_idx = q.rx_cnt;
							n.rx_cnt = q.rx_cnt + 14'h1;
						end else begin
							n.ovf = 1'b1;
						end
						if (q.tx_cnt < tx_buf_limit) begin
							n.tx_cnt = q.tx_cnt + 14'h1;
						end else begin
							n.oread = 1'b1;
						end
						// Slot just emptied is refilled two bytes ahead
						if (q.next_idx < tx_buf_limit) begin
							n.fetch_pend[q.par] = 1'b1;
							n.fetch_idx[q.par] = q.next_idx;
						end else begin
							n.slot[q.par] = tx_excess_flag_fill_char;
						end
						if (q.next_idx != `STS_LIM_MAX) begin
							n.next_idx = q.next_idx + 14'h1;
						end
						n.par = ~q.par;
					end
					if (csn_rise) begin
						n.ph = STS_PH_DRAIN;
						n.drain_cnt = `STS_DRAIN_CYC;
						n.fetch_pend = 2'b00;
					end
				end
				STS_PH_IGNORED: begin
					// MOSI bytes are dropped here even if freed
					if (csn_rise) begin
						n.ph = STS_PH_IDLE;
					end
				end
				STS_PH_DRAIN: begin
					// Last byte toggle may lag the select edge by a cycle
					if (byte_ev) begin
						if (q.rx_cnt < rx_buf_limit) begin
							n.wr_pend = 1'b1;
							n.wr_data = lb.hold;
							n.wr_idx = q.rx_cnt;
							n.rx_cnt = q.rx_cnt + 14'h1;
						end else begin
							n.ovf = 1'b1;
						end
						if (q.tx_cnt < tx_buf_limit) begin
							n.tx_cnt = q.tx_cnt + 14'h1;
						end else begin
							n.oread = 1'b1;
						end
					end
					if (q.drain_cnt != 2'h0) begin
						n.drain_cnt = q.drain_cnt - 2'h1;
					end else if (!q.wr_pend && !q.mem.req && !byte_ev) begin
						n.done_ev = 1'b1;
						n.ph = STS_PH_IDLE;
						n.rx_tally = q.rx_cnt;
						n.tx_tally = q.tx_cnt;
						n.take_pend = 1'b0;
						// One handover covers shortcut and pending take
						if (shortcut_done_take || q.take_pend || take_task) begin
							n.sem = STS_SEM_CPU;
							n.taken_ev = 1'b1;
						end else begin
							n.sem = STS_SEM_FREE;
						end
					end
				end
				default: begin
					n.ph = STS_PH_IDLE;
				end
			endcase
			// Memory channels: writer has priority; one access in flight.
			// Pointers are read live, nothing locks them.
			if (q.mem.req) begin
				if (mem_rsp.ack) begin
					n.mem.req = 1'b0;
					if (!q.mem.we) begin
						n.slot[q.busy_slot] = mem_rsp.rdata;
					end else if (q.busy_full) begin
						n.full_ev = 1'b1;
					end
				end
			end else if (q.wr_pend) begin
				n.wr_pend = 1'b0;
				n.mem.req = 1'b1;
				n.mem.we = 1'b1;
				n.mem.addr = rx_buf_pointer + {18'h0, q.wr_idx};
				n.mem.wdata = q.wr_data;
				n.busy_full = (q.wr_idx + 14'h1) == rx_buf_limit;
			end else if (q.fetch_pend != 2'b00) begin
				n.fetch_pend[fsel] = 1'b0;
				n.mem.req = 1'b1;
				n.mem.we = 1'b0;
				n.mem.addr = tx_buf_pointer + {18'h0, q.fetch_idx[fsel]};
				n.busy_slot = fsel;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			q <= '{sem: STS_SEM_FREE, ph: STS_PH_IDLE, csn_s1: 1'b1,
				csn_s2: 1'b1, csn_s3: 1'b1, miso_oe_b: 1'b1, default: '0};
		end else begin
			q <= n;
		end
	end

	assign sem_taken_event = q.taken_ev;
	assign xfer_done_event = q.done_ev;
	assign rx_buffer_full_event = q.full_ev;
	assign rx_overflow_flag = q.ovf;
	assign tx_excess_flag = q.oread;
	assign rx_byte_tally = q.rx_tally;
	assign tx_byte_tally = q.tx_tally;
	assign sem_owner = q.sem;
	assign mem_req = q.mem;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	a_enable_no_event: assert property (
		$rose(enable) && !take_task |=> q.sem == STS_SEM_CPU && !q.taken_ev)
		else $error("enable must give semaphore without event");
	a_take_owned: assert property (
		enable && q.en_d && take_task && q.sem == STS_SEM_CPU |=> q.taken_ev)
		else $error("take while owned must raise event next cycle");
	a_give_foreign: assert property (
		enable && give_task && q.sem == STS_SEM_ENGINE &&
		q.ph == STS_PH_GRANTED |=> q.sem == STS_SEM_ENGINE)
		else $error("give while not owned changed the semaphore");
	a_race_cpu_wins: assert property (
		enable && q.en_d && csn_fall && take_task && q.sem == STS_SEM_FREE &&
		q.ph == STS_PH_IDLE |=> q.sem == STS_SEM_CPU &&
		q.ph == STS_PH_IGNORED && q.slot[0] == ignored_fill_char)
		else $error("contention not resolved for the processor");
	a_busy_take_held: assert property (
		enable && q.en_d && take_task && q.sem == STS_SEM_ENGINE &&
		q.ph == STS_PH_GRANTED && !csn_rise |=> !q.taken_ev && q.take_pend)
		else $error("take during grant was not deferred");
	a_done_releases: assert property (
		q.done_ev |-> q.sem != STS_SEM_ENGINE && q.ph == STS_PH_IDLE &&
		$past(q.ph) == STS_PH_DRAIN)
		else $error("done without releasing the engine");
	a_done_mem_idle: assert property (
		q.done_ev |-> !q.mem.req && !q.wr_pend && !$past(q.mem.req))
		else $error("done raised while memory still busy");
	a_shortcut_give: assert property (
		q.done_ev && $past(shortcut_done_take) |-> q.sem == STS_SEM_CPU &&
		q.taken_ev)
		else $error("shortcut did not hand semaphore over");
	a_single_serve: assert property (
		q.done_ev && q.taken_ev |-> !q.take_pend ##1 !q.taken_ev ||
		$past(take_task))
		else $error("pending take served twice");
	a_overflow_drop: assert property (
		enable && byte_ev && q.ph == STS_PH_GRANTED &&
		q.rx_cnt >= rx_buf_limit |=> q.ovf && q.rx_cnt == $past(q.rx_cnt))
		else $error("excess byte not discarded with overflow");
	a_ignored_fill: assert property (
		q.ph == STS_PH_IGNORED && $stable(ignored_fill_char) |->
		q.slot[0] == ignored_fill_char && q.slot[1] == ignored_fill_char)
		else $error("ignored transaction sends wrong fill");

	c_granted_done: cover property (
		q.ph == STS_PH_DRAIN ##[1:20] q.done_ev);
	c_ignored: cover property (q.ph == STS_PH_IDLE ##1 q.ph == STS_PH_IGNORED);
	c_buffer_full: cover property (q.full_ev);
	c_overflow: cover property ($rose(q.ovf));

endmodule // sts_target

`default_nettype wire

// ==== verification/sts_master_model.sv ====
`timescale 1ns/10ps
`default_nettype none

module sts_master_model (
	input wire logic cpol,
	input wire logic cpha,
	input wire logic miso,
	output logic sck,
	output logic csn_b,
	output logic mosi
);
	initial begin
		sck = 1'b0;
		csn_b = 1'b1;
		mosi = 1'b1;
	end

	// Four bytes, MSB first; the clock only moves while selected
	task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
		sck = cpol;
		csn_b = 1'b0;
		// Lead time covers the select sync plus two tx prefetches
		#120;
		for (int i = 31; i >= 0; i--) begin
			if (cpha) sck = ~cpol;
			mosi = tx[i];
			#3;
			sck = cpha ? cpol : ~cpol;
			rx[i] = miso;
			#3;
			if (!cpha) sck = cpol;
			// Gap keeps each byte above twelve system cycles
			if (i % 8 == 0) #12;
		end
		#6;
		csn_b = 1'b1;
		// A released line must not keep showing its last bit
		mosi = ~tx[0];
	endtask
endmodule // sts_master_model

`default_nettype wire

// ==== verification/sts_target_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "sts_defines.svh"

module sts_target_tb_top
	import sts_pkg::*;
;
	logic core_clk, rst_b, enable, cpol, cpha, shortcut;
	logic take_task, give_task, status_clear;
	logic [31:0] tx_ptr, rx_ptr, mo, mi;
	logic [13:0] tx_lim, rx_lim, rx_byte_tally, tx_byte_tally;
	logic [7:0] ign_ch, orc_ch;
	logic sem_taken_event, xfer_done_event, rx_buffer_full_event;
	logic rx_overflow_flag, tx_excess_flag;
	sts_sem_t sem_owner;
	sts_mem_req_t mem_req;
	sts_mem_rsp_t mem_rsp;
	logic sck, csn_b, mosi, miso, miso_oe_b;
	wire logic miso_w;
	logic [7:0] wr_buf [0:7];
	int num_errors, check_count, done_cnt, taken_cnt, full_cnt, wr_cnt;
	int d0, t0, f0, w0;
	integer seed;

	assign miso_w = miso_oe_b ? 1'bz : miso;

	sts_target dut_u (.core_clk(core_clk), .rst_b(rst_b), .enable(enable),
		.cpol(cpol), .cpha(cpha), .shortcut_done_take(shortcut),
		.take_task(take_task), .give_task(give_task),
		.status_clear(status_clear), .tx_buf_pointer(tx_ptr),
		.rx_buf_pointer(rx_ptr), .tx_buf_limit(tx_lim), .rx_buf_limit(rx_lim),
		.ignored_fill_char(ign_ch), .tx_excess_flag_fill_char(orc_ch),
		.sem_taken_event(sem_taken_event), .xfer_done_event(xfer_done_event),
		.rx_buffer_full_event(rx_buffer_full_event),
		.rx_overflow_flag(rx_overflow_flag), .tx_excess_flag(tx_excess_flag),
		.rx_byte_tally(rx_byte_tally), .tx_byte_tally(tx_byte_tally),
		.sem_owner(sem_owner), .mem_req(mem_req), .mem_rsp(mem_rsp),
		.sck(sck), .csn_b(csn_b), .mosi(mosi), .miso(miso),
		.miso_oe_b(miso_oe_b));

	sts_master_model mdl_u (.cpol(cpol), .cpha(cpha), .miso(miso_w),
		.sck(sck), .csn_b(csn_b), .mosi(mosi));

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// Memory answers one cycle after a request; read data follows address
	always @(posedge core_clk) begin
		mem_rsp.ack <= #1 mem_req.req && !mem_rsp.ack;
		mem_rsp.rdata <= #1 mem_req.addr[7:0] ^ 8'ha5;
		if (mem_req.req && mem_rsp.ack && mem_req.we) begin
			wr_buf[3'(mem_req.addr - rx_ptr)] = mem_req.wdata;
			wr_cnt++;
		end
		if (xfer_done_event === 1'b1) done_cnt++;
		if (sem_taken_event === 1'b1) taken_cnt++;
		if (rx_buffer_full_event === 1'b1) full_cnt++;
	end

	function automatic logic [31:0] exp_miso(input logic [31:0] p);
		return {p[7:0] ^ 8'ha5, 8'(p + 1) ^ 8'ha5, orc_ch, orc_ch};
	endfunction

	task automatic close_out();
		if (num_errors == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_own(input sts_sem_t exp);
		chk({30'h0, sem_owner}, {30'h0, exp});
	endtask

	// 0 give, 1 take, 2 clear status
	task automatic pulse(input int which);
		@(posedge core_clk) #1;
		take_task = (which == 1);
		give_task = (which == 0);
		status_clear = (which == 2);
		@(posedge core_clk) #1;
		take_task = 1'b0;
		give_task = 1'b0;
		status_clear = 1'b0;
	endtask

	task automatic wait_done();
		for (int i = 0; i < 60 && done_cnt == d0; i++) @(posedge core_clk) #1;
		if (done_cnt == d0) begin
			num_errors++;
			$display("[FAIL] %0t no done event", $time);
			close_out();
		end
	endtask

	task automatic snap();
		d0 = done_cnt;
		t0 = taken_cnt;
		f0 = full_cnt;
		w0 = wr_cnt;
		mo = $random(seed);
	endtask

	initial begin
		seed = 32'h4608;
		{rst_b, enable, cpol, cpha, shortcut} = 5'h0;
		{take_task, give_task, status_clear} = 3'h0;
		mem_rsp = '0;
		{num_errors, check_count, done_cnt, taken_cnt, full_cnt, wr_cnt} = 0;
		tx_ptr = $random(seed);
		rx_ptr = $random(seed);
		ign_ch = $random(seed);
		orc_ch = $random(seed);
		tx_lim = 14'h2;
		rx_lim = 14'h3;
		repeat (6) @(posedge core_clk);
		#1 rst_b = 1'b1;
		@(posedge core_clk) #1 enable = 1'b1;
		repeat (3) @(posedge core_clk);
		#1 chk_own(STS_SEM_CPU);
		chk(taken_cnt, 0);
		pulse(1);
		@(posedge core_clk) #1 chk(taken_cnt, 1);
		chk_own(STS_SEM_CPU);
		// Processor holds the semaphore, then frees it mid-frame
		snap();
		fork
			mdl_u.frame(mo, mi);
			begin
				#150 pulse(0);
			end
		join
		repeat (20) @(posedge core_clk);
		#1 chk(mi, {4{ign_ch}});
		chk(wr_cnt - w0, 0);
		chk(done_cnt - d0, 0);
		chk_own(STS_SEM_FREE);
		pulse(0);
		@(posedge core_clk) #1 chk_own(STS_SEM_FREE);
		chk(taken_cnt - t0, 0);
		// Take lands on the select decision edge, third after the fall
		snap();
		fork
			mdl_u.frame(mo, mi);
			begin
				@(posedge core_clk);
				pulse(1);
			end
		join
		repeat (20) @(posedge core_clk);
		#1 chk(mi, {4{ign_ch}});
		chk(taken_cnt - t0, 1);
		chk(done_cnt - d0, 0);
		chk(wr_cnt - w0, 0);
		chk_own(STS_SEM_CPU);
		pulse(0);
		// Every mode, same pointers each time
		for (int m = 0; m < 4; m++) begin
			{cpol, cpha} = 2'(m);
			pulse(2);
			chk({rx_overflow_flag, tx_excess_flag}, 2'b00);
			snap();
			mdl_u.frame(mo, mi);
			wait_done();
			chk(wr_cnt - w0, 3);
			chk(mi, exp_miso(tx_ptr));
			chk({wr_buf[0], wr_buf[1], wr_buf[2]}, mo[31:8]);
			chk({rx_byte_tally, tx_byte_tally}, {14'h3, 14'h2});
			chk({rx_overflow_flag, tx_excess_flag}, 2'b11);
			chk(full_cnt - f0, 1);
			chk_own(STS_SEM_FREE);
		end
		// Zero limits: every byte is fill, nothing reaches memory
		tx_lim = 14'h0;
		rx_lim = 14'h0;
		pulse(2);
		snap();
		mdl_u.frame(mo, mi);
		wait_done();
		chk(mi, {4{orc_ch}});
		chk(wr_cnt - w0, 0);
		chk(full_cnt - f0, 0);
		chk({rx_byte_tally, tx_byte_tally}, 28'h0);
		chk({rx_overflow_flag, tx_excess_flag}, 2'b11);
		chk_own(STS_SEM_FREE);
		// Take during a granted frame with the shortcut on
		shortcut = 1'b1;
		snap();
		fork
			mdl_u.frame(mo, mi);
			begin
				#150 pulse(1);
				pulse(0);
				chk_own(STS_SEM_ENGINE);
			end
		join
		wait_done();
		repeat (3) @(posedge core_clk);
		#1 chk(taken_cnt - t0, 1);
		chk_own(STS_SEM_CPU);
		close_out();
	end
endmodule // sts_target_tb_top

`default_nettype wire
